// file: pkg/psq_map.svh
// Register offsets, field positions, reset values and widths of the sequencer
`ifndef PSQ_MAP_SVH
`define PSQ_MAP_SVH

`define PSQ_ADDR_W 12
`define PSQ_OFS_CTRL 12'h000
`define PSQ_OFS_RDIST 12'h004
`define PSQ_OFS_STAT 12'h008
`define PSQ_OFS_MOVE 12'h00C
`define PSQ_OFS_REP 12'h100
`define PSQ_OFS_TGT 12'h200
`define PSQ_TBL_MASK 12'hF00
`define PSQ_IDX_LSB 2
`define PSQ_IDX_MSB 6

`define PSQ_CTRL_SEQ 0
`define PSQ_CTRL_TERM 1
`define PSQ_CTRL_MZ 2
`define PSQ_CTRL_CONT 3
`define PSQ_CTRL_DIR_LSB 4
`define PSQ_CTRL_DIR_MSB 6
`define PSQ_CTRL_RST 32'h0000_0002
`define PSQ_RDIST_RST 32'h0000_0000

`define PSQ_MOVE_ABS 0
`define PSQ_MOVE_TEST 1
`define PSQ_MOVE_AUTOHOME 2

`define PSQ_REC_FIRST 5'h01
`define PSQ_REC_MAX_FULL 5'h1F
`define PSQ_REC_MAX_MZ 5'h0F
`define PSQ_REC_HOME 5'h00
`define PSQ_REP_END 8'h00
`define PSQ_REP_ONE 8'h01

`define PSQ_HTRANS_NONSEQ 2'h2
`define PSQ_HTRANS_SEQ 2'h3

`endif

// file: pkg/psq_pkg.sv
// Types shared by the positioning record sequencer
package psq_pkg;

  // Direction options for absolute moves in reset operation
  typedef enum logic [2:0] {
    PSQ_DIR_ANY = 3'b000,
    PSQ_DIR_POS = 3'b001,
    PSQ_DIR_SHORT = 3'b010,
    PSQ_DIR_NEG = 3'b011,
    PSQ_DIR_KEEP = 3'b100
  } psq_dir_opt_type;

  // Direction handed to the motion generator
  typedef enum logic [1:0] {
    PSQ_MOVE_FREE = 2'b00,
    PSQ_MOVE_FWD = 2'b01,
    PSQ_MOVE_REV = 2'b10
  } psq_move_dir_type;

  // Sequencer states
  typedef enum logic [1:0] {
    PSQ_ST_IDLE = 2'b00,
    PSQ_ST_RUN = 2'b01,
    PSQ_ST_HALT = 2'b10
  } psq_state_type;

  // Command to the motion generator
  typedef struct packed {
    logic valid;
    logic home;
    logic resume;
    logic stop;
    logic [4:0] rec;
    psq_move_dir_type dir;
    logic [31:0] target;
  } psq_cmd_type;

  // Feedback from the motion generator
  typedef struct packed {
    logic done;
    logic fwd_travel;
    logic [31:0] brake_pos;
  } psq_fb_type;

endpackage : psq_pkg

// file: src/psq_top.sv
// Positioning record sequencer with AHB-Lite register slave
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "psq_map.svh"

// Operation
// - Zero repetition count ends sequential run
// - Zero count: resample address, start immediately
// - Sequential starts repeat record until count used
// - Single mode: every start but a resume samples address
// - Stop active low; termination is configurable
// - Terminating stop: no resume of aborted move
// - Single, terminating: fresh address, full run
// - Sequential, terminating: new sequence from address
// - Non-terminating stop: next start resumes move
// - Resume ignores current address inputs
// - Start after stop needs stop input high
// - Continuous single terminating: full distance restart
// - Nonzero reset distance enables reset operation
// - Five direction options for absolute moves
// - Direction from predicted braking position
// - Options off outside zero to reset distance
// - Options off for test and auto-home moves
// - Shortest path at half distance is undefined
// - Sequence advances, wraps to record one
// - Address inputs form binary record number
// - Thirty-one records, fifteen with zero switch
// - Address zero starts a homing run
module psq_top #(
  parameter int REC_W = 5,
  parameter int REP_W = 8,
  parameter int POS_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic stop_inactive_input,
  input wire logic start_edge_input,
  input wire logic record_addr_bit0,
  input wire logic record_addr_bit1,
  input wire logic record_addr_bit2,
  input wire logic record_addr_bit3,
  input wire logic record_addr_bit4,
  input wire psq_pkg::psq_fb_type motion_fb,
  output psq_pkg::psq_cmd_type motion_cmd
);

  localparam int NREC = 1 << REC_W;

  // Refuse geometries the address pins and command struct cannot carry
  generate
    if (REC_W != 5 || POS_W != 32 || REP_W < 1 || REP_W > 32) begin : g_chk
      $error("psq_top: unsupported parameter values");
    end
  endgenerate

  // Record table kept locally; record zero is the homing slot
  logic [REP_W-1:0] rep_mem [NREC];
  logic [POS_W-1:0] tgt_mem [NREC];

  logic [31:0] ctrl_r;
  logic [31:0] rdist_r;
  logic [31:0] move_r;
  logic [`PSQ_ADDR_W-1:0] bus_addr_r;
  logic bus_wr_r;
  psq_pkg::psq_state_type state_r;
  logic [REC_W-1:0] cur_rec_r;
  logic [REP_W-1:0] rep_left_r;
  logic seq_active_r;
  logic start_s1_r;
  logic start_s2_r;
  logic start_s3_r;
  logic stop_seen_r;

  // Table index of a bus address
  function automatic logic [REC_W-1:0] tbl_idx(
    input logic [`PSQ_ADDR_W-1:0] a
  );
    tbl_idx = a[`PSQ_IDX_MSB:`PSQ_IDX_LSB];
  endfunction : tbl_idx

  // Region of a bus address within the record tables
  function automatic logic in_tbl(
    input logic [`PSQ_ADDR_W-1:0] a,
    input logic [`PSQ_ADDR_W-1:0] base
  );
    in_tbl = (a & `PSQ_TBL_MASK) == base
      && a[`PSQ_ADDR_W-5:`PSQ_IDX_MSB+1] == '0;
  endfunction : in_tbl

  // Configuration fields
  wire seq_mode = ctrl_r[`PSQ_CTRL_SEQ];
  wire stop_term = ctrl_r[`PSQ_CTRL_TERM];
  wire mz_switch = ctrl_r[`PSQ_CTRL_MZ];
  wire cont_mode = ctrl_r[`PSQ_CTRL_CONT];
  wire [2:0] dir_opt = ctrl_r[`PSQ_CTRL_DIR_MSB:`PSQ_CTRL_DIR_LSB];
  wire reset_op = rdist_r != '0;

  // Address phase accepted by this slave
  wire bus_take = hsel && hready && htrans[1];
  wire [`PSQ_ADDR_W-1:0] a_now = haddr[`PSQ_ADDR_W-1:0];

  // Binary record address, top bit lost to the zero switch
  wire [REC_W-1:0] pin_addr = {record_addr_bit4 & ~mz_switch,
    record_addr_bit3, record_addr_bit2, record_addr_bit1,
    record_addr_bit0};
  wire [REC_W-1:0] rec_max = mz_switch ?
    `PSQ_REC_MAX_MZ : `PSQ_REC_MAX_FULL;

  // Start edge from the second and third stage, never the first
  wire start_edge = start_s2_r & ~start_s3_r;
  wire stop_req = ~stop_inactive_input;
  wire start_ok = start_edge && stop_inactive_input;

  // Sequencer decision made on an accepted start
  logic [REC_W-1:0] nxt_idx;
  logic [REC_W-1:0] go_rec;
  logic [REP_W-1:0] go_rep;
  logic go_resume;
  always_comb begin
    nxt_idx = (cur_rec_r >= rec_max) ? `PSQ_REC_FIRST :
      REC_W'(cur_rec_r + 1'b1);
    go_rec = pin_addr;
    go_rep = rep_mem[pin_addr];
    go_resume = 1'b0;
    if (state_r == psq_pkg::PSQ_ST_HALT) begin
      go_rec = cur_rec_r;
      go_rep = rep_left_r;
      go_resume = 1'b1;
    end else if (seq_mode && seq_active_r) begin
      if (rep_left_r > `PSQ_REP_ONE) begin
        go_rec = cur_rec_r;
        go_rep = REP_W'(rep_left_r - 1'b1);
      end else if (rep_mem[nxt_idx] != `PSQ_REP_END) begin
        go_rec = nxt_idx;
        go_rep = rep_mem[nxt_idx];
      end
      // Otherwise the zero count ends the run and pins are used now
    end
  end

  // Direction choice for absolute moves in reset operation
  logic [POS_W-1:0] tgt_sel;
  logic [POS_W:0] fwd_dist;
  psq_pkg::psq_move_dir_type dir_sel;
  always_comb begin
    tgt_sel = tgt_mem[go_rec];
    // Distance ahead measured from the braking point, not the position
    if (tgt_sel >= motion_fb.brake_pos) begin
      fwd_dist = {1'b0, tgt_sel - motion_fb.brake_pos};
    end else begin
      fwd_dist = {1'b0, tgt_sel} + {1'b0, rdist_r}
        - {1'b0, motion_fb.brake_pos};
    end
    dir_sel = psq_pkg::PSQ_MOVE_FREE;
    if (reset_op && move_r[`PSQ_MOVE_ABS] && !move_r[`PSQ_MOVE_TEST]
        && !move_r[`PSQ_MOVE_AUTOHOME]
        && !tgt_sel[POS_W-1] && tgt_sel < rdist_r) begin
      case (psq_pkg::psq_dir_opt_type'(dir_opt))
        psq_pkg::PSQ_DIR_POS: dir_sel = psq_pkg::PSQ_MOVE_FWD;
        psq_pkg::PSQ_DIR_NEG: dir_sel = psq_pkg::PSQ_MOVE_REV;
        psq_pkg::PSQ_DIR_SHORT: begin
          // Exactly half way falls to reverse; callers must avoid it
          if ({fwd_dist[POS_W-1:0], 1'b0} < {1'b0, rdist_r}) begin
            dir_sel = psq_pkg::PSQ_MOVE_FWD;
          end else begin
            dir_sel = psq_pkg::PSQ_MOVE_REV;
          end
        end
        psq_pkg::PSQ_DIR_KEEP: begin
          dir_sel = motion_fb.fwd_travel ?
            psq_pkg::PSQ_MOVE_FWD : psq_pkg::PSQ_MOVE_REV;
        end
        default: dir_sel = psq_pkg::PSQ_MOVE_FREE;
      endcase
    end
  end

  // Start synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_s1_r <= 1'b0;
      start_s2_r <= 1'b0;
      start_s3_r <= 1'b0;
    end else if (clk_en) begin
      start_s1_r <= start_edge_input;
      start_s2_r <= start_s1_r;
      start_s3_r <= start_s2_r;
    end
  end

  // Bus address phase capture; zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_addr_r <= '0;
      bus_wr_r <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      bus_wr_r <= bus_take && hwrite;
      if (bus_take) begin
        bus_addr_r <= a_now;
      end
    end
  end

  // Value a write in its data phase leaves behind; a read taken on that
  // same edge would otherwise return the stale word
  logic fwd_hit;
  logic [31:0] fwd_val;
  always_comb begin
    fwd_hit = bus_wr_r && bus_addr_r == a_now;
    fwd_val = hwdata;
    if (bus_addr_r == `PSQ_OFS_CTRL) begin
      fwd_val = {25'h0, hwdata[`PSQ_CTRL_DIR_MSB:0]};
    end else if (bus_addr_r == `PSQ_OFS_MOVE) begin
      fwd_val = {29'h0, hwdata[`PSQ_MOVE_AUTOHOME:0]};
    end else if (in_tbl(bus_addr_r, `PSQ_OFS_REP)) begin
      fwd_val = {{(32-REP_W){1'b0}}, hwdata[REP_W-1:0]};
    end else if (!in_tbl(bus_addr_r, `PSQ_OFS_TGT)
        && bus_addr_r != `PSQ_OFS_RDIST) begin
      // Status and unmapped words are not writable, nothing to forward
      fwd_hit = 1'b0;
    end
  end

  // Read data registered at the address phase so it stands in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (clk_en && bus_take && !hwrite) begin
      if (fwd_hit) begin
        hrdata <= fwd_val;
      end else if (a_now == `PSQ_OFS_CTRL) begin
        hrdata <= ctrl_r;
      end else if (a_now == `PSQ_OFS_RDIST) begin
        hrdata <= rdist_r;
      end else if (a_now == `PSQ_OFS_MOVE) begin
        hrdata <= move_r;
      end else if (a_now == `PSQ_OFS_STAT) begin
        hrdata <= {{(32-REP_W-REC_W-4){1'b0}}, rep_left_r, cur_rec_r,
          seq_active_r, 1'b0, state_r};
      end else if (in_tbl(a_now, `PSQ_OFS_REP)) begin
        hrdata <= {{(32-REP_W){1'b0}}, rep_mem[tbl_idx(a_now)]};
      end else if (in_tbl(a_now, `PSQ_OFS_TGT)) begin
        hrdata <= tgt_mem[tbl_idx(a_now)];
      end else begin
        hrdata <= '0;
      end
    end
  end

  // Configuration registers written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `PSQ_CTRL_RST;
      rdist_r <= `PSQ_RDIST_RST;
      move_r <= '0;
    end else if (clk_en && bus_wr_r) begin
      if (bus_addr_r == `PSQ_OFS_CTRL) begin
        ctrl_r <= {25'h0, hwdata[`PSQ_CTRL_DIR_MSB:0]};
      end
      if (bus_addr_r == `PSQ_OFS_RDIST) begin
        rdist_r <= hwdata;
      end
      if (bus_addr_r == `PSQ_OFS_MOVE) begin
        move_r <= {29'h0, hwdata[`PSQ_MOVE_AUTOHOME:0]};
      end
    end
  end

  // Record tables; a zero count marks the end of a sequence
  always_ff @(posedge hclk) begin
    if (clk_en && bus_wr_r) begin
      if (in_tbl(bus_addr_r, `PSQ_OFS_REP)) begin
        rep_mem[tbl_idx(bus_addr_r)] <= hwdata[REP_W-1:0];
      end
      if (in_tbl(bus_addr_r, `PSQ_OFS_TGT)) begin
        tgt_mem[tbl_idx(bus_addr_r)] <= hwdata;
      end
    end
  end

  // Sequencer state; stop has priority over a start in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= psq_pkg::PSQ_ST_IDLE;
      cur_rec_r <= '0;
      rep_left_r <= '0;
      seq_active_r <= 1'b0;
      stop_seen_r <= 1'b0;
    end else if (clk_en) begin
      stop_seen_r <= stop_req;
      case (state_r)
        psq_pkg::PSQ_ST_IDLE, psq_pkg::PSQ_ST_RUN: begin
          if (stop_req) begin
            if (stop_term || state_r == psq_pkg::PSQ_ST_IDLE) begin
              state_r <= psq_pkg::PSQ_ST_IDLE;
              seq_active_r <= stop_term ? 1'b0 : seq_active_r;
            end else begin
              state_r <= psq_pkg::PSQ_ST_HALT;
            end
          end else if (start_ok) begin
            state_r <= psq_pkg::PSQ_ST_RUN;
            cur_rec_r <= go_rec;
            rep_left_r <= go_rep;
            seq_active_r <= seq_mode && go_rec != `PSQ_REC_HOME;
          end else if (motion_fb.done) begin
            state_r <= psq_pkg::PSQ_ST_IDLE;
          end
        end
        psq_pkg::PSQ_ST_HALT: begin
          if (start_ok) begin
            state_r <= psq_pkg::PSQ_ST_RUN;
          end
        end
        default: state_r <= psq_pkg::PSQ_ST_IDLE;
      endcase
    end
  end

  // Motion command, one-cycle valid per start or stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      motion_cmd <= '0;
    end else if (clk_en) begin
      motion_cmd.valid <= 1'b0;
      motion_cmd.stop <= 1'b0;
      if (stop_req && !stop_seen_r) begin
        motion_cmd.valid <= 1'b1;
        motion_cmd.stop <= 1'b1;
      end else if (start_ok && !stop_req) begin
        motion_cmd.valid <= 1'b1;
        motion_cmd.rec <= go_rec;
        motion_cmd.home <= go_rec == `PSQ_REC_HOME;
        // Continuous single restart is a full move from here
        motion_cmd.resume <= go_resume && !(cont_mode && stop_term);
        motion_cmd.dir <= dir_sel;
        motion_cmd.target <= tgt_sel;
      end
    end
  end

endmodule : psq_top

// file: sim/psq_checker.sv
// Port-level assertions for the positioning record sequencer
`timescale 1ns/1ps
module psq_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic stop_inactive_input,
  input wire logic start_edge_input,
  input wire psq_pkg::psq_cmd_type motion_cmd
);
  logic [4:0] run_rec_r;
  logic cv;
  logic st;
  // Short names for the command pulse and the stop pin
  assign cv = motion_cmd.valid;
  assign st = stop_inactive_input;
  // Last fresh move; a resume must repeat it, whatever the pins say
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) run_rec_r <= 5'h00;
    else if (cv && !motion_cmd.stop && !motion_cmd.resume)
      run_rec_r <= motion_cmd.rec;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_valid_pulse: assert property (cv |=> !cv)
    else $error("command valid held too long");
  chk_start_cmd: assert property ($rose(start_edge_input) && st
    ##1 (start_edge_input && st) [*2] |-> ##[1:4] cv)
    else $error("start edge gave no command");
  chk_stop_cmd: assert property ($fell(st)
    |-> ##[1:6] (cv && motion_cmd.stop)) else $error("stop gave no command");
  chk_stopped_idle: assert property (!st [*6]
    |-> !(cv && !motion_cmd.stop)) else $error("move while stop held");
  chk_resume_rec: assert property (cv && motion_cmd.resume
    |-> motion_cmd.rec == run_rec_r) else $error("resume changed record");
  chk_home_zero: assert property (cv && !motion_cmd.stop
    && !motion_cmd.home |-> motion_cmd.rec != 5'h00)
    else $error("record zero run as a move");
  chk_fields_hold: assert property (!cv
    |-> $stable(motion_cmd.rec) && $stable(motion_cmd.target))
    else $error("command fields changed without valid");
endmodule : psq_checker
bind psq_top psq_checker i_chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp),
  .stop_inactive_input(stop_inactive_input),
  .start_edge_input(start_edge_input), .motion_cmd(motion_cmd));

// file: sim/psq_mgen_model.sv
// Motion generator stand-in answering the sequencer's commands
`timescale 1ns/1ps
module psq_mgen_model #(
  parameter int DONE_DLY = 40
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire psq_pkg::psq_cmd_type motion_cmd,
  input wire logic [31:0] brake_set,
  input wire logic fwd_set,
  output psq_pkg::psq_fb_type motion_fb
);
  int cnt_r;
  // A move ends after a fixed time; a stop freezes it with no done
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_r <= 0;
    else if (motion_cmd.valid) cnt_r <= motion_cmd.stop ? 0 : DONE_DLY;
    else if (cnt_r > 0) cnt_r <= cnt_r - 1;
  end
  // Feedback seen by the sequencer
  assign motion_fb.done = (cnt_r == 1);
  assign motion_fb.fwd_travel = fwd_set;
  assign motion_fb.brake_pos = brake_set;
endmodule : psq_mgen_model

// file: sim/testbench.sv
// Self-checking bench for the positioning record sequencer
`timescale 1ns/1ps
`include "psq_map.svh"
module testbench;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic stop_pin;
  logic start_pin;
  logic [4:0] addr_pins;
  logic [31:0] brake;
  logic fwd;
  psq_pkg::psq_fb_type motion_fb;
  psq_pkg::psq_cmd_type motion_cmd;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  psq_top i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .stop_inactive_input(stop_pin), .start_edge_input(start_pin),
    .record_addr_bit0(addr_pins[0]), .record_addr_bit1(addr_pins[1]),
    .record_addr_bit2(addr_pins[2]), .record_addr_bit3(addr_pins[3]),
    .record_addr_bit4(addr_pins[4]), .motion_fb(motion_fb),
    .motion_cmd(motion_cmd));
  psq_mgen_model i_mgen (.hclk(hclk), .hresetn(hresetn),
    .motion_cmd(motion_cmd), .brake_set(brake), .fwd_set(fwd),
    .motion_fb(motion_fb));
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Compares valid, home, resume and record; record is moot on homing
  task automatic chkc(input psq_pkg::psq_cmd_type c, input logic h,
    input logic r, input logic [4:0] n);
    chk({c.valid, c.home, c.resume, h ? 5'h00 : c.rec}, {1'b1, h, r, n});
  endtask : chkc
  // One single AHB-Lite transfer; waits on hready in both phases
  task automatic bus(input logic we, input logic [11:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= we;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic wait_cmd(output psq_pkg::psq_cmd_type c);
    int i;
    c = '0;
    for (i = 0; i < 12 && c.valid !== 1'b1; i++) begin
      @(posedge hclk);
      c = motion_cmd;
    end
  endtask : wait_cmd
  // Address settles before the edge, then scrambles once taken
  task automatic start(input logic [4:0] a, output psq_pkg::psq_cmd_type c);
    addr_pins <= a;
    repeat (2) @(posedge hclk);
    start_pin <= 1'b1;
    wait_cmd(c);
    start_pin <= 1'b0;
    addr_pins <= ~a;
    repeat (6) @(posedge hclk);
  endtask : start
  task automatic stop_run;
    psq_pkg::psq_cmd_type c;
    stop_pin <= 1'b0;
    wait_cmd(c);
    chk({31'h0, c.stop}, 32'h1);
    start(5'h0B, c);
    chk({31'h0, c.valid}, 32'h0);
    stop_pin <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask : stop_run
  task automatic test_regs;
    logic [31:0] r;
    int n;
    bus(1'b0, `PSQ_OFS_CTRL, 32'h0, r);
    chk(r, `PSQ_CTRL_RST);
    bus(1'b0, `PSQ_OFS_RDIST, 32'h0, r);
    chk(r, `PSQ_RDIST_RST);
    wr(12'h040, 32'h0000_00FF);
    bus(1'b0, 12'h040, 32'h0, r);
    chk(r, 32'h0);
    wr(`PSQ_OFS_STAT, 32'hFFFF_FFFF);
    bus(1'b0, `PSQ_OFS_STAT, 32'h0, r);
    chk({30'h0, r[1:0]}, 32'h0);
    // Every slot written, so no unknown target or count reaches a command
    for (n = 0; n < 32; n++) begin
      r = (n == 6) ? 32'h0 : (n == 4 || n == 7) ? 32'h2 : 32'h1;
      wr(12'(`PSQ_OFS_REP + 4 * n), r);
      wr(12'(`PSQ_OFS_TGT + 4 * n), 32'(n) << 4);
    end
    bus(1'b0, 12'(`PSQ_OFS_REP + 16), 32'h0, r);
    chk(r, 32'h2);
    bus(1'b0, 12'(`PSQ_OFS_TGT + 12), 32'h0, r);
    chk(r, 32'h30);
    $display("register test done");
  endtask : test_regs
  task automatic test_single;
    psq_pkg::psq_cmd_type c;
    logic [4:0] a[5] = '{5'h01, 5'h07, 5'h0D, 5'h1F, 5'h00};
    int i;
    wr(`PSQ_OFS_CTRL, 32'h2);
    for (i = 0; i < 5; i++) begin
      start(a[i], c);
      chkc(c, a[i] == 5'h00, 1'b0, a[i]);
      chk(c.target, 32'(a[i]) << 4);
    end
    // Zero switch takes the top address pin away
    wr(`PSQ_OFS_CTRL, 32'h6);
    start(5'h1F, c);
    chkc(c, 1'b0, 1'b0, 5'h0F);
    wr(`PSQ_OFS_CTRL, 32'hA);
    start(5'h03, c);
    stop_run();
    start(5'h05, c);
    chkc(c, 1'b0, 1'b0, 5'h05);
    $display("single positioning test done");
  endtask : test_single
  // Record 6 holds count zero, so pins are read again there
  task automatic test_seq;
    psq_pkg::psq_cmd_type c;
    logic [4:0] a[10] = '{3, 9, 9, 9, 7, 9, 9, 30, 9, 9};
    logic [4:0] e[10] = '{3, 4, 4, 5, 7, 7, 8, 30, 31, 1};
    int i;
    wr(`PSQ_OFS_CTRL, 32'h3);
    for (i = 0; i < 10; i++) begin
      if (i == 7) stop_run();
      start(a[i], c);
      chkc(c, 1'b0, 1'b0, e[i]);
    end
    $display("sequential positioning test done");
  endtask : test_seq
  task automatic test_resume;
    psq_pkg::psq_cmd_type c;
    psq_pkg::psq_cmd_type c2;
    int i;
    for (i = 0; i < 2; i++) begin
      wr(`PSQ_OFS_CTRL, 32'(1 - i));
      // First pass continues the running sequence, second is single
      start(5'h05, c);
      chkc(c, 1'b0, 1'b0, (i == 0) ? 5'h02 : 5'h05);
      stop_run();
      start(5'h14, c2);
      chkc(c2, 1'b0, 1'b1, (i == 0) ? 5'h02 : 5'h05);
    end
    $display("resume test done");
  endtask : test_resume
  // Options 0 any 1 pos 2 short 3 neg 4 keep; moves 0 free 1 fwd 2 rev
  task automatic dcase(input logic [2:0] d, input logic [31:0] rd,
    input logic [31:0] tg, input logic [31:0] br, input logic [2:0] mv,
    input logic fw, input logic [1:0] e);
    psq_pkg::psq_cmd_type c;
    wr(`PSQ_OFS_CTRL, {25'h0, d, 4'h2});
    wr(`PSQ_OFS_RDIST, rd);
    wr(`PSQ_OFS_MOVE, {29'h0, mv});
    wr(12'(`PSQ_OFS_TGT + 8), tg);
    brake <= br;
    fwd <= fw;
    start(5'h02, c);
    chk({30'h0, c.dir}, {30'h0, e});
  endtask : dcase
  task automatic test_dir;
    dcase(3'h0, 32'h168, 32'h64, 32'h0, 3'h1, 1'b0, 2'h0);
    dcase(3'h1, 32'h168, 32'h64, 32'h0, 3'h1, 1'b0, 2'h1);
    dcase(3'h3, 32'h168, 32'h64, 32'h0, 3'h1, 1'b0, 2'h2);
    dcase(3'h4, 32'h168, 32'h64, 32'h0, 3'h1, 1'b1, 2'h1);
    dcase(3'h4, 32'h168, 32'h64, 32'h0, 3'h1, 1'b0, 2'h2);
    dcase(3'h2, 32'h168, 32'h64, 32'hFA, 3'h1, 1'b0, 2'h2);
    dcase(3'h2, 32'h168, 32'h64, 32'h0, 3'h1, 1'b0, 2'h1);
    dcase(3'h1, 32'h168, 32'h168, 32'h0, 3'h1, 1'b0, 2'h0);
    dcase(3'h1, 32'h168, 32'h64, 32'h0, 3'h3, 1'b0, 2'h0);
    dcase(3'h1, 32'h168, 32'h64, 32'h0, 3'h5, 1'b0, 2'h0);
    dcase(3'h1, 32'h0, 32'h64, 32'h0, 3'h1, 1'b0, 2'h0);
    $display("direction test done");
  endtask : test_dir
  // Clock of 25 ns
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Hang guard, well above the thousand or so cycles the tests need
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    stop_pin = 1'b1;
    start_pin = 1'b0;
    addr_pins = 5'h00;
    brake = 32'h0;
    fwd = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    test_regs();
    test_single();
    test_seq();
    test_resume();
    test_dir();
    final_report();
  end
endmodule : testbench
